// ---- bus_partition_pkg.sv ----
package bus_partition_pkg;

    // register byte addresses on the avalon slave
    localparam logic [7:0]  OFS_RAM_USER_PROGRAM_BASE   = 8'h00;
    localparam logic [7:0]  OFS_RAM_SIZE_REPORT         = 8'h04;
    localparam logic [7:0]  OFS_FLASH_USER_PROGRAM_BASE = 8'h08;
    localparam logic [7:0]  OFS_FLASH_SIZE_REPORT       = 8'h0c;
    localparam logic [7:0]  OFS_REGION_STATUS           = 8'h10;

    // writable fields of the two base registers
    localparam int          RAM_BASE_FIELD_LSB          = 10;
    localparam int          RAM_BASE_FIELD_MSB          = 15;
    localparam int          FLASH_BASE_FIELD_LSB        = 11;
    localparam int          FLASH_BASE_FIELD_MSB        = 19;
    localparam logic [31:0] RAM_BASE_WRITE_MASK         = 32'h0000fc00;
    localparam logic [31:0] FLASH_BASE_WRITE_MASK       = 32'h000ff800;
    localparam logic [31:0] BASE_RESET_VALUE            = 32'h00000000;

    // size report values per device variant
    localparam logic [31:0] RAM_SIZE_4K                 = 32'h00001000;
    localparam logic [31:0] RAM_SIZE_8K                 = 32'h00002000;
    localparam logic [31:0] RAM_SIZE_16K                = 32'h00004000;
    localparam logic [31:0] RAM_SIZE_32K                = 32'h00008000;
    localparam logic [31:0] RAM_SIZE_64K                = 32'h00010000;
    localparam logic [31:0] FLASH_SIZE_16K              = 32'h00004000;
    localparam logic [31:0] FLASH_SIZE_32K              = 32'h00008000;
    localparam logic [31:0] FLASH_SIZE_64K              = 32'h00010000;
    localparam logic [31:0] FLASH_SIZE_128K             = 32'h00020000;
    localparam logic [31:0] FLASH_SIZE_256K             = 32'h00040000;

    // region status register layout
    localparam int          STAT_RAM_REGION_LSB         = 0;
    localparam int          STAT_RAM_OUT_OF_RANGE       = 2;
    localparam int          STAT_RAM_SEEN               = 3;
    localparam int          STAT_FLASH_USER             = 4;
    localparam int          STAT_FLASH_OUT_OF_RANGE     = 5;
    localparam int          STAT_FLASH_SEEN             = 6;

    // avalon response codes
    localparam logic [1:0]  RESP_OKAY                   = 2'b00;
    localparam logic [1:0]  RESP_DECODE_ERROR           = 2'b11;
    localparam logic [31:0] READ_ZERO                   = 32'h00000000;

    typedef enum logic [1:0] {
        region_kernel_data,
        region_kernel_program,
        region_user_data,
        region_user_program
    } region_type;

    // a zero base disables its boundary: the region below runs to the end
    function automatic logic [31:0] effective_bound(input logic [31:0] base, input logic [31:0] size);
        effective_bound = (base == 32'h00000000) ? size : base;
    endfunction

endpackage

// ---- partition_classifier.sv ----
`timescale 1ns/100ps

module partition_classifier
    import bus_partition_pkg::*;
#(
    parameter int NUM_BOUNDS = 3
) (
    input  wire logic [31:0]                 offset_in,
    input  wire logic [NUM_BOUNDS-1:0][31:0] bounds_in,
    input  wire logic [31:0]                 size_in,
    output logic      [1:0]                  index_out,
    output logic                             out_of_range_out
);

    logic [NUM_BOUNDS-1:0] at_or_above;

    // one comparator per ascending boundary
    generate
        for (genvar i = 0; i < NUM_BOUNDS; i++) begin : g_cmp
            assign at_or_above[i] = offset_in >= effective_bound(bounds_in[i], size_in); // [R15]
        end
    endgenerate

    // boundaries ascend, so the count of passed ones names the region
    always_comb begin
        logic [1:0] count;
        count = 2'h0;
        for (int i = 0; i < NUM_BOUNDS; i++) begin
            count = count + {1'b0, at_or_above[i]};
        end
        index_out        = count;
        out_of_range_out = offset_in >= size_in;
    end

endmodule

// ---- bus_matrix_memory_partition.sv ----
`timescale 1ns/100ps
// How it works
// [R01] Bits 31 to 16 of the ram user-program base read as zero and writes to them are dropped.
// [R02] A non-zero value in bits 15 to 10 of that base marks the start of user program space in data ram.
// [R03] Software must set the ram user-program base above the ram user-data base.
// [R04] Bits 9 to 0 of the ram user-program base are read-only zero, giving 1 KB steps.
// [R05] Reset clears both user-program bases, leaving all of data ram to kernel data.
// [R06] Software must keep the ram user-program base at or below the reported data ram size.
// [R07] The data ram size report is a 32-bit read-only register that writes cannot change.
// [R08] The data ram size report holds a fixed byte count from 4 KB to 64 KB chosen by the variant.
// [R09] Bits 31 to 20 of the flash user-program base read as zero and writes to them are dropped.
// [R10] Bits 19 to 11 of the flash user-program base mark the start of user program space in flash.
// [R11] Bits 10 to 0 of the flash user-program base are read-only zero, giving 2 KB steps.
// [R12] Software must keep the flash user-program base at or below the reported flash size.
// [R13] The flash size report is a fixed read-only byte count from 16 KB to 256 KB chosen by the variant.
// [R14] Software must place the ram user-data base above the ram kernel-program base.
// [R15] Each ram and flash access offset is compared with the bases to find its kernel or user region.

module bus_matrix_memory_partition
    import bus_partition_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE_BYTES   = RAM_SIZE_64K,
    parameter logic [31:0] FLASH_SIZE_BYTES = FLASH_SIZE_256K
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic      [1:0]  avs_response_out,
    output logic             avs_waitrequest_out,
    // bases held by the neighbouring matrix registers
    input  wire logic [31:0] ram_kernel_program_base_in,
    input  wire logic [31:0] ram_user_data_base_in,
    // access offsets, relative to the start of each memory
    input  wire logic        ram_access_valid_in,
    input  wire logic [31:0] ram_access_offset_in,
    input  wire logic        flash_access_valid_in,
    input  wire logic [31:0] flash_access_offset_in,
    // classification results, one cycle after the access
    output logic             ram_result_valid_out,
    output region_type       ram_region_out,
    output logic             ram_out_of_range_out,
    output logic             flash_result_valid_out,
    output logic             flash_user_program_out,
    output logic             flash_out_of_range_out,
    // current bases, for the matrix address decoders
    output logic      [31:0] ram_user_program_base_out,
    output logic      [31:0] flash_user_program_base_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [31:0] ram_upb;
        logic [31:0] flash_upb;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic        ram_valid;
        region_type  ram_region;
        logic        ram_oor;
        logic        ram_seen;
        logic        flash_valid;
        logic        flash_user;
        logic        flash_oor;
        logic        flash_seen;
    } state_type;

    localparam state_type STATE_RESET = '{
        ram_upb:     BASE_RESET_VALUE,
        flash_upb:   BASE_RESET_VALUE,
        ack:         1'b0,
        rdata:       READ_ZERO,
        resp:        RESP_OKAY,
        ram_valid:   1'b0,
        ram_region:  region_kernel_data,
        ram_oor:     1'b0,
        ram_seen:    1'b0,
        flash_valid: 1'b0,
        flash_user:  1'b0,
        flash_oor:   1'b0,
        flash_seen:  1'b0
    };

    state_type state_q;
    state_type state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // region classification

    logic [2:0][31:0] ram_bounds;
    logic [0:0][31:0] flash_bounds;
    logic [1:0]       ram_index;
    logic             ram_oor_now;
    logic [1:0]       flash_index;
    logic             flash_oor_now;

    // kernel program, user data, user program: ascending by software's ordering
    assign ram_bounds[0]   = ram_kernel_program_base_in; // [R14]
    assign ram_bounds[1]   = ram_user_data_base_in; // [R03]
    assign ram_bounds[2]   = state_q.ram_upb; // [R02]
    assign flash_bounds[0] = state_q.flash_upb; // [R10]

    partition_classifier #(
        .NUM_BOUNDS       (3)
    ) u_ram_classifier (
        .offset_in        (ram_access_offset_in),
        .bounds_in        (ram_bounds),
        .size_in          (RAM_SIZE_BYTES),
        .index_out        (ram_index),
        .out_of_range_out (ram_oor_now)
    );

    partition_classifier #(
        .NUM_BOUNDS       (1)
    ) u_flash_classifier (
        .offset_in        (flash_access_offset_in),
        .bounds_in        (flash_bounds),
        .size_in          (FLASH_SIZE_BYTES),
        .index_out        (flash_index),
        .out_of_range_out (flash_oor_now)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic        request;
    logic        commit;
    logic [31:0] byte_mask;
    logic [31:0] status_word;

    assign request   = avs_read_in | avs_write_in;
    // the answer comes on the second edge of a request; the first edge only stages read data
    assign commit    = request & state_q.ack;
    assign byte_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                        {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

    always_comb begin
        status_word = READ_ZERO;
        status_word[STAT_RAM_REGION_LSB +: 2] = state_q.ram_region;
        status_word[STAT_RAM_OUT_OF_RANGE]    = state_q.ram_oor;
        status_word[STAT_RAM_SEEN]            = state_q.ram_seen;
        status_word[STAT_FLASH_USER]          = state_q.flash_user;
        status_word[STAT_FLASH_OUT_OF_RANGE]  = state_q.flash_oor;
        status_word[STAT_FLASH_SEEN]          = state_q.flash_seen;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_d = state_q;

        // handshake: ack rises after one wait cycle, drops after the answer
        state_d.ack = request & ~state_q.ack;

        // stage read data and response during the wait cycle
        if (request && !state_q.ack) begin
            state_d.resp  = RESP_OKAY;
            state_d.rdata = READ_ZERO;
            if (avs_address_in == OFS_RAM_USER_PROGRAM_BASE) begin
                state_d.rdata = state_q.ram_upb;
            end else if (avs_address_in == OFS_RAM_SIZE_REPORT) begin
                state_d.rdata = RAM_SIZE_BYTES; // [R07] [R08]
            end else if (avs_address_in == OFS_FLASH_USER_PROGRAM_BASE) begin
                state_d.rdata = state_q.flash_upb;
            end else if (avs_address_in == OFS_FLASH_SIZE_REPORT) begin
                state_d.rdata = FLASH_SIZE_BYTES; // [R13]
            end else if (avs_address_in == OFS_REGION_STATUS) begin
                state_d.rdata = status_word;
            end else begin
                // unmapped or misaligned: zero data, decode error
                state_d.resp = RESP_DECODE_ERROR;
            end
        end

        // writes land on the edge where waitrequest is low; size reports ignore them
        if (commit && avs_write_in) begin
            if (avs_address_in == OFS_RAM_USER_PROGRAM_BASE) begin
                // only bits 15..10 are kept; upper and lower bits stay zero
                state_d.ram_upb = (state_q.ram_upb & ~(RAM_BASE_WRITE_MASK & byte_mask))
                                | (avs_writedata_in & RAM_BASE_WRITE_MASK & byte_mask); // [R01] [R04]
            end else if (avs_address_in == OFS_FLASH_USER_PROGRAM_BASE) begin
                state_d.flash_upb = (state_q.flash_upb & ~(FLASH_BASE_WRITE_MASK & byte_mask))
                                  | (avs_writedata_in & FLASH_BASE_WRITE_MASK & byte_mask); // [R09] [R11]
            end
        end

        // classification results; no range check on bases, software keeps them in bounds
        state_d.ram_valid = ram_access_valid_in; // [R06]
        if (ram_access_valid_in) begin
            state_d.ram_region = region_type'(ram_index); // [R15]
            state_d.ram_oor    = ram_oor_now;
            state_d.ram_seen   = 1'b1;
        end

        state_d.flash_valid = flash_access_valid_in; // [R12]
        if (flash_access_valid_in) begin
            state_d.flash_user = flash_index[0]; // [R15]
            state_d.flash_oor  = flash_oor_now;
            state_d.flash_seen = 1'b1;
        end

        // reading status clears the seen flags, but a new access in the same cycle wins
        if (commit && avs_read_in && avs_address_in == OFS_REGION_STATUS) begin
            state_d.ram_seen   = ram_access_valid_in;
            state_d.flash_seen = flash_access_valid_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= STATE_RESET; // [R05]
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_waitrequest_out         = request & ~state_q.ack;
    assign avs_readdata_out            = state_q.rdata;
    assign avs_response_out            = state_q.resp;
    assign ram_result_valid_out        = state_q.ram_valid;
    assign ram_region_out              = state_q.ram_region;
    assign ram_out_of_range_out        = state_q.ram_oor;
    assign flash_result_valid_out      = state_q.flash_valid;
    assign flash_user_program_out      = state_q.flash_user;
    assign flash_out_of_range_out      = state_q.flash_oor;
    assign ram_user_program_base_out   = state_q.ram_upb;
    assign flash_user_program_base_out = state_q.flash_upb;

endmodule

// ---- bus_matrix_memory_partition_assertions.sv ----
`timescale 1ns/100ps
module partition_checker
    import bus_partition_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE_BYTES   = RAM_SIZE_64K,
    parameter logic [31:0] FLASH_SIZE_BYTES = FLASH_SIZE_256K
) (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        ram_access_valid_in,
    input wire logic [31:0] ram_access_offset_in,
    input wire logic        ram_result_valid_out,
    input wire logic        ram_out_of_range_out,
    input wire logic        flash_access_valid_in,
    input wire logic [31:0] flash_access_offset_in,
    input wire logic        flash_out_of_range_out,
    input wire logic [31:0] ram_user_program_base_out,
    input wire logic [31:0] flash_user_program_base_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    ram_upper_zero_a: assert property (ram_user_program_base_out[31:16] == 16'h0000)
        else $error("ram base upper bits not zero");
    ram_low_zero_a: assert property (ram_user_program_base_out[9:0] == 10'h000)
        else $error("ram base low bits not zero");
    flash_upper_zero_a: assert property (flash_user_program_base_out[31:20] == 12'h000)
        else $error("flash base upper bits not zero");
    flash_low_zero_a: assert property (flash_user_program_base_out[10:0] == 11'h000)
        else $error("flash base low bits not zero");
    bases_reset_a: assert property ($rose(reset_n_in) |-> ram_user_program_base_out == 32'h00000000
        && flash_user_program_base_out == 32'h00000000) else $error("bases not cleared by reset");
    ram_base_write_a: assert property (avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h00
        && avs_byteenable_in == 4'hf |=> ram_user_program_base_out == ($past(avs_writedata_in) & 32'h0000fc00))
        else $error("ram base write not taken");
    flash_base_write_a: assert property (avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h08
        && avs_byteenable_in == 4'hf |=> flash_user_program_base_out == ($past(avs_writedata_in) & 32'h000ff800))
        else $error("flash base write not taken");
    ram_size_read_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 8'h04
        |-> avs_readdata_out == RAM_SIZE_BYTES) else $error("ram size report wrong");
    flash_size_read_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 8'h0c
        |-> avs_readdata_out == FLASH_SIZE_BYTES) else $error("flash size report wrong");
    ram_range_a: assert property (ram_access_valid_in |=> ram_result_valid_out
        && ram_out_of_range_out == ($past(ram_access_offset_in) >= RAM_SIZE_BYTES)) else $error("ram range wrong");
    flash_range_a: assert property (flash_access_valid_in |=> flash_out_of_range_out
        == ($past(flash_access_offset_in) >= FLASH_SIZE_BYTES)) else $error("flash range wrong");
endmodule

bind bus_matrix_memory_partition partition_checker #(
    .RAM_SIZE_BYTES(RAM_SIZE_BYTES), .FLASH_SIZE_BYTES(FLASH_SIZE_BYTES)) chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .ram_access_valid_in(ram_access_valid_in), .ram_access_offset_in(ram_access_offset_in),
    .ram_result_valid_out(ram_result_valid_out), .ram_out_of_range_out(ram_out_of_range_out),
    .flash_access_valid_in(flash_access_valid_in), .flash_access_offset_in(flash_access_offset_in),
    .flash_out_of_range_out(flash_out_of_range_out), .ram_user_program_base_out(ram_user_program_base_out),
    .flash_user_program_base_out(flash_user_program_base_out));

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
    import bus_partition_pkg::*;
    localparam logic [31:0] RSZ = RAM_SIZE_16K;
    localparam logic [31:0] FSZ = FLASH_SIZE_64K;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] be = 4'hf;
    logic [31:0] kp_base = 32'h00000000;
    logic [31:0] ud_base = 32'h00000000;
    logic ram_v = 1'b0;
    logic flash_v = 1'b0;
    logic [31:0] ram_off = 32'h00000000;
    logic [31:0] flash_off = 32'h00000000;
    logic [31:0] rdata, ram_base_o, flash_base_o, ram_m, flash_m, st_m, got_data;
    logic [1:0] resp, got_resp;
    logic waitreq, ram_rv, ram_oor, flash_rv, flash_up, flash_oor;
    region_type ram_reg;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int k;
    always #50 clk_in = ~clk_in;
    bus_matrix_memory_partition #(.RAM_SIZE_BYTES(RSZ), .FLASH_SIZE_BYTES(FSZ)) dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(addr), .avs_read_in(rd_en),
        .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_response_out(resp), .avs_waitrequest_out(waitreq), .ram_kernel_program_base_in(kp_base),
        .ram_user_data_base_in(ud_base), .ram_access_valid_in(ram_v), .ram_access_offset_in(ram_off),
        .flash_access_valid_in(flash_v), .flash_access_offset_in(flash_off), .ram_result_valid_out(ram_rv),
        .ram_region_out(ram_reg), .ram_out_of_range_out(ram_oor), .flash_result_valid_out(flash_rv),
        .flash_user_program_out(flash_up), .flash_out_of_range_out(flash_oor),
        .ram_user_program_base_out(ram_base_o), .flash_user_program_base_out(flash_base_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            report_and_stop;
        end
    end
    // waitrequest and read data are taken at the rising edge, before that edge updates the slave
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk_in);
        addr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= d;
        be <= b;
        do begin
            @(posedge clk_in);
        end while (waitreq !== 1'b0);
        got_data = rdata;
        got_resp = resp;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    function automatic logic [31:0] lane_mask(input logic [3:0] b);
        lane_mask = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] m;
        bus(1'b1, a, d, b);
        m = lane_mask(b) & ((a == 8'h00) ? 32'h0000fc00 : 32'h000ff800);
        if (a == 8'h00) ram_m = (ram_m & ~m) | (d & m);
        if (a == 8'h08) flash_m = (flash_m & ~m) | (d & m);
    endtask
    task automatic read_all;
        logic [7:0] a;
        logic [31:0] exp;
        for (int i = 0; i < 7; i++) begin
            a = (i < 4) ? 8'(i * 4) : ((i == 4) ? 8'h10 : ((i == 5) ? 8'h14 : 8'h02));
            exp = (i == 0) ? ram_m : (i == 1) ? RSZ : (i == 2) ? flash_m : (i == 3) ? FSZ
                : (i == 4) ? st_m : 32'h00000000;
            bus(1'b0, a, 32'h00000000, 4'hf);
            check(got_data, exp);
            check(32'(got_resp), (i < 5) ? 32'h00000000 : 32'h00000003);
            // reading the status word clears both seen flags
            if (i == 4) st_m = st_m & ~32'h00000048;
        end
        check(ram_base_o, ram_m);
        check(flash_base_o, flash_m);
    endtask
    function automatic logic [31:0] eff(input logic [31:0] b, input logic [31:0] s);
        eff = (b == 32'h00000000) ? s : b;
    endfunction
    task automatic access(input logic [31:0] ro, input logic [31:0] fo);
        logic [31:0] r;
        @(posedge clk_in);
        ram_v <= 1'b1;
        flash_v <= 1'b1;
        ram_off <= ro;
        flash_off <= fo;
        @(posedge clk_in);
        ram_v <= 1'b0;
        flash_v <= 1'b0;
        #1;
        r = 32'(eff(kp_base, RSZ) <= ro) + 32'(eff(ud_base, RSZ) <= ro) + 32'(eff(ram_m, RSZ) <= ro);
        check(32'({ram_rv, flash_rv, ram_oor, flash_oor}), 32'({2'b11, ro >= RSZ, fo >= FSZ}));
        check(32'(ram_reg), r);
        check(32'(flash_up), 32'(fo >= eff(flash_m, FSZ)));
        st_m = {25'h0000000, 1'b1, fo >= FSZ, fo >= eff(flash_m, FSZ), 1'b1, ro >= RSZ, r[1:0]};
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        k = $urandom(69478);
        ram_m = 32'h00000000;
        flash_m = 32'h00000000;
        st_m = 32'h00000000;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        read_all;
        access(32'h00000000, FSZ - 32'h00000001);
        repeat (12) begin
            // bases stay ordered and inside the memory, as software must keep them
            k = 1 + $urandom % (RSZ >> 10);
            reg_write(8'h00, (32'(k) << 10) | ($urandom & 32'hffff03ff), ($urandom % 2) ? 4'hf : 4'($urandom));
            reg_write(8'h08, ((1 + $urandom % (FSZ >> 11)) << 11) | ($urandom & 32'hfff007ff),
                ($urandom % 2) ? 4'hf : 4'($urandom));
            reg_write(8'h04, $urandom, 4'hf);
            reg_write(8'h0c, $urandom, 4'hf);
            reg_write(8'h14, $urandom, 4'hf);
            read_all;
            @(posedge clk_in);
            // lane masks may leave the old base, so order against the base actually held
            ud_base <= (ram_m == 32'h00000000) ? 32'h00000000 : 32'($urandom % (ram_m >> 10)) << 10;
            kp_base <= 32'h00000000;
            @(posedge clk_in);
            if (ud_base != 0) kp_base <= 32'($urandom % (ud_base >> 10)) << 10;
            access(ram_m, flash_m);
            access(RSZ, FSZ);
            repeat (6) access($urandom % (RSZ + 32'h00000400), $urandom % (FSZ + 32'h00000800));
        end
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        ram_m = 32'h00000000;
        flash_m = 32'h00000000;
        st_m = 32'h00000000;
        read_all;
        report_and_stop;
    end
endmodule
